// [verilog/ucs_pkg.sv]
// constants and carrier types for the l3 and snoop event counter
// assumes a single uncore clock and an apb register port
package ucs_pkg;

	// ----------------------------------------------------------
	// register map
	// ----------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_AUX = 12'h004;
	localparam logic [11:0] ADDR_COUNT = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00c;

	// ctrl fields
	localparam int CTRL_EVT_LSB = 0;
	localparam int CTRL_UMASK_LSB = 8;
	localparam int CTRL_EN_BIT = 16;
	localparam int AUX_W = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [3:0] AUX_RST = 4'h0;

	// ----------------------------------------------------------
	// event numbers
	// ----------------------------------------------------------
	localparam logic [7:0] EVT_L3_HIT = 8'h08;
	localparam logic [7:0] EVT_L3_MISS = 8'h09;
	localparam logic [7:0] EVT_FILL = 8'h0a;
	localparam logic [7:0] EVT_EVICT = 8'h0b;
	localparam logic [7:0] EVT_SNOOP = 8'h0c;

	// unit mask bit positions
	localparam int UM_READ = 0;
	localparam int UM_WB = 1;
	localparam int UM_SNP = 2;
	localparam int UM_GOTO_S = 0;
	localparam int UM_GOTO_I = 1;
	localparam int UM_GOTO_S_HIT = 2;
	localparam int UM_GOTO_I_HIT = 3;

	// aux state-mask bit positions
	localparam int AUX_M = 0;
	localparam int AUX_E = 1;
	localparam int AUX_S = 2;
	localparam int AUX_F = 3;

	// ----------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------
	typedef enum logic [1:0] {
		UCS_K_READ,
		UCS_K_WB,
		UCS_K_SNP
	} ucs_kind_t;

	typedef enum logic [2:0] {
		UCS_ST_M,
		UCS_ST_E,
		UCS_ST_S,
		UCS_ST_I,
		UCS_ST_F
	} ucs_state_t;

	typedef struct packed {
		logic valid;
		logic hit;
		ucs_kind_t kind;
	} ucs_acc_t;

	typedef struct packed {
		logic valid;
		ucs_state_t state;
		logic fwd_m_rio;
	} ucs_fill_t;

	typedef struct packed {
		logic valid;
		ucs_state_t state;
		logic home_remote;
	} ucs_evict_t;

	typedef struct packed {
		logic valid;
		logic to_invalid;
		ucs_state_t prior;
	} ucs_snoop_t;

	typedef struct packed {
		logic valid;
		logic home_remote;
	} ucs_wb_t;

endpackage : ucs_pkg

// [verilog/ucs_match.sv]
// one event source compared against the programmed selection
// assumes occ bits are already in unit-mask layout
`timescale 1ns/1ps
`default_nettype none
module ucs_match #(
	parameter logic [7:0] EVT = 8'h00
) (
	// selection
	input wire logic en,
	input wire logic [7:0] evt_sel,
	input wire logic [7:0] umask,
	// occurrence
	input wire logic [7:0] occ,
	// result
	output logic hit
);

	// ----------------------------------------------------------
	// compare
	// ----------------------------------------------------------
	// combined masks are unions of single bits, so an and suffices
	always_comb begin
		hit = en && (evt_sel == EVT) && ((umask & occ) != 8'h00);
	end

endmodule : ucs_match
`default_nettype wire

// [verilog/ucs_top.sv]
// l3 hit/miss, fill, eviction and snoop event counter with apb port
// assumes occurrence inputs come from logic on pclk, one per cycle
//
// Operation
// - hit event, read mask counts read hits
// - hit event, write mask counts writeback hits
// - hit event, probe mask counts snoop hits
// - hit event, mask 03H counts reads and writes
// - miss event, read mask counts read misses
// - miss event, write mask counts writeback misses
// - miss event, probe mask counts snoop misses
// - miss event, mask 03H counts read and writeback misses
// - fill event counts fills by selected state
// - modified fill only when forwarded by rio
// - evict event counts victims by prior state
// - modified victim written back to its home
// - snoop event, mask 01H counts goto shared
// - snoop event, mask 02H counts goto invalid
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ucs_top #(
	parameter int CNT_W = 32
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// occurrences from the cache pipeline
	input wire ucs_pkg::ucs_acc_t acc,
	input wire ucs_pkg::ucs_fill_t fill,
	input wire ucs_pkg::ucs_evict_t evict,
	input wire ucs_pkg::ucs_snoop_t snoop,
	// cache side actions
	output ucs_pkg::ucs_state_t fill_grant,
	output logic fill_grant_valid,
	output ucs_pkg::ucs_wb_t wb_req
);

	// ----------------------------------------------------------
	// registers
	// ----------------------------------------------------------
	logic [31:0] ctrl_ff;
	logic [3:0] aux_ff;
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_count;
	logic wrap_ff;
	logic [4:0] last_hit_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	ucs_pkg::ucs_state_t fill_grant_ff;
	logic fill_grant_valid_ff;
	ucs_pkg::ucs_wb_t wb_req_ff;
	ucs_pkg::ucs_state_t nxt_grant;

	// ----------------------------------------------------------
	// decoded selection
	// ----------------------------------------------------------
	logic en;
	logic [7:0] evt_sel;
	logic [7:0] umask;

	always_comb begin
		en = ctrl_ff[ucs_pkg::CTRL_EN_BIT];
		evt_sel = ctrl_ff[ucs_pkg::CTRL_EVT_LSB +: 8];
		umask = ctrl_ff[ucs_pkg::CTRL_UMASK_LSB +: 8];
	end

	// ----------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------
	logic setup;
	logic wr_done;
	logic mapped;
	logic [31:0] wmask;
	logic [31:0] rd_mux;

	always_comb begin
		setup = psel && !penable;
		wr_done = psel && penable && pready_ff && pwrite;
		mapped = (paddr == ucs_pkg::ADDR_CTRL) ||
			(paddr == ucs_pkg::ADDR_AUX) ||
			(paddr == ucs_pkg::ADDR_COUNT) ||
			(paddr == ucs_pkg::ADDR_STATUS);
		wmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
			{8{pstrb[1]}}, {8{pstrb[0]}}};
	end

	// narrow fields read in the low bits, upper bits zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
		ucs_pkg::ADDR_CTRL: begin
			rd_mux[16:0] = ctrl_ff[16:0];
		end
		ucs_pkg::ADDR_AUX: begin
			rd_mux[3:0] = aux_ff;
		end
		ucs_pkg::ADDR_COUNT: begin
			rd_mux = 32'(count_ff);
		end
		ucs_pkg::ADDR_STATUS: begin
			rd_mux[4:0] = last_hit_ff;
			rd_mux[8] = wrap_ff;
		end
		default: begin
			rd_mux = 32'h0000_0000;
		end
		endcase
	end

	// ----------------------------------------------------------
	// apb answer
	// ----------------------------------------------------------
	// one wait-free access phase: pready rises for the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (ce) begin
			pready_ff <= setup;
			pslverr_ff <= setup && !mapped;
			if (setup && !pwrite) begin
				prdata_ff <= mapped ? rd_mux : 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------
	// control registers
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= ucs_pkg::CTRL_RST;
		end else if (ce) begin
			if (wr_done && paddr == ucs_pkg::ADDR_CTRL) begin
				ctrl_ff <= (ctrl_ff & ~wmask) | (pwdata & wmask);
			end
		end
	end

	// aux state mask qualifies the snoop hit sub-events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_ff <= ucs_pkg::AUX_RST;
		end else if (ce) begin
			if (wr_done && paddr == ucs_pkg::ADDR_AUX && pstrb[0]) begin
				aux_ff <= pwdata[3:0];
			end
		end
	end

	// ----------------------------------------------------------
	// occurrence bits in unit-mask layout
	// ----------------------------------------------------------
	logic [7:0] acc_bits;
	logic [7:0] fill_bits;
	logic [7:0] evict_bits;
	logic [7:0] snoop_bits;
	logic [3:0] prior_oh;

	always_comb begin
		acc_bits = 8'h00;
		if (acc.valid) begin
			case (acc.kind)
			ucs_pkg::UCS_K_READ: begin
				acc_bits[ucs_pkg::UM_READ] = 1'b1;
			end
			ucs_pkg::UCS_K_WB: begin
				acc_bits[ucs_pkg::UM_WB] = 1'b1;
			end
			ucs_pkg::UCS_K_SNP: begin
				acc_bits[ucs_pkg::UM_SNP] = 1'b1;
			end
			default: begin
				acc_bits = 8'h00;
			end
			endcase
		end
	end

	// fill state as m/e/s/f bits, taken from the granted state
	always_comb begin
		fill_bits = 8'h00;
		if (fill.valid) begin
			case (nxt_grant)
			ucs_pkg::UCS_ST_M: begin
				fill_bits[0] = 1'b1;
			end
			ucs_pkg::UCS_ST_E: begin
				fill_bits[1] = 1'b1;
			end
			ucs_pkg::UCS_ST_S: begin
				fill_bits[2] = 1'b1;
			end
			ucs_pkg::UCS_ST_F: begin
				fill_bits[3] = 1'b1;
			end
			default: begin
				fill_bits = 8'h00;
			end
			endcase
		end
	end

	// victim state as m/e/s/i/f bits
	always_comb begin
		evict_bits = 8'h00;
		if (evict.valid) begin
			case (evict.state)
			ucs_pkg::UCS_ST_M: begin
				evict_bits[0] = 1'b1;
			end
			ucs_pkg::UCS_ST_E: begin
				evict_bits[1] = 1'b1;
			end
			ucs_pkg::UCS_ST_S: begin
				evict_bits[2] = 1'b1;
			end
			ucs_pkg::UCS_ST_I: begin
				evict_bits[3] = 1'b1;
			end
			ucs_pkg::UCS_ST_F: begin
				evict_bits[4] = 1'b1;
			end
			default: begin
				evict_bits = 8'h00;
			end
			endcase
		end
	end

	// prior state in aux layout; an invalid line matches no mask
	always_comb begin
		prior_oh = 4'h0;
		case (snoop.prior)
		ucs_pkg::UCS_ST_M: begin
			prior_oh[ucs_pkg::AUX_M] = 1'b1;
		end
		ucs_pkg::UCS_ST_E: begin
			prior_oh[ucs_pkg::AUX_E] = 1'b1;
		end
		ucs_pkg::UCS_ST_S: begin
			prior_oh[ucs_pkg::AUX_S] = 1'b1;
		end
		ucs_pkg::UCS_ST_F: begin
			prior_oh[ucs_pkg::AUX_F] = 1'b1;
		end
		default: begin
			prior_oh = 4'h0;
		end
		endcase
	end

	always_comb begin
		snoop_bits = 8'h00;
		if (snoop.valid) begin
			snoop_bits[ucs_pkg::UM_GOTO_S] = !snoop.to_invalid;
			snoop_bits[ucs_pkg::UM_GOTO_I] = snoop.to_invalid;
			snoop_bits[ucs_pkg::UM_GOTO_S_HIT] = !snoop.to_invalid &&
				((prior_oh & aux_ff) != 4'h0);
			snoop_bits[ucs_pkg::UM_GOTO_I_HIT] = snoop.to_invalid &&
				((prior_oh & aux_ff) != 4'h0);
		end
	end

	// ----------------------------------------------------------
	// event matchers
	// ----------------------------------------------------------
	logic [4:0] hits;
	logic [7:0] hit_occ;
	logic [7:0] miss_occ;

	// mask 03H covers reads and writes by the same bitwise test
	always_comb begin
		hit_occ = acc.hit ? acc_bits : 8'h00;
		miss_occ = acc.hit ? 8'h00 : acc_bits;
	end

	ucs_match #(.EVT(ucs_pkg::EVT_L3_HIT)) u_hit (
		.en(en),
		.evt_sel(evt_sel),
		.umask(umask),
		.occ(hit_occ),
		.hit(hits[0])
	);

	// writeback misses should never occur; counted if they do
	ucs_match #(.EVT(ucs_pkg::EVT_L3_MISS)) u_miss (
		.en(en),
		.evt_sel(evt_sel),
		.umask(umask),
		.occ(miss_occ),
		.hit(hits[1])
	);

	ucs_match #(.EVT(ucs_pkg::EVT_FILL)) u_fill (
		.en(en),
		.evt_sel(evt_sel),
		.umask(umask),
		.occ(fill_bits),
		.hit(hits[2])
	);

	ucs_match #(.EVT(ucs_pkg::EVT_EVICT)) u_evict (
		.en(en),
		.evt_sel(evt_sel),
		.umask(umask),
		.occ(evict_bits),
		.hit(hits[3])
	);

	ucs_match #(.EVT(ucs_pkg::EVT_SNOOP)) u_snoop (
		.en(en),
		.evt_sel(evt_sel),
		.umask(umask),
		.occ(snoop_bits),
		.hit(hits[4])
	);

	// ----------------------------------------------------------
	// counter
	// ----------------------------------------------------------
	logic [2:0] inc;
	logic cnt_wr;

	// all matchers share evt_sel, so at most one source counts in one cycle
	always_comb begin
		inc = 3'd0;
		for (int i = 0; i < 5; i++) begin
			inc = inc + {2'b00, hits[i]};
		end
		cnt_wr = wr_done && paddr == ucs_pkg::ADDR_COUNT;
		nxt_count = count_ff + CNT_W'(inc);
	end

	// a software write wins over a same-cycle increment
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= '0;
		end else if (ce) begin
			if (cnt_wr) begin
				count_ff <= CNT_W'(pwdata);
			end else begin
				count_ff <= nxt_count;
			end
		end
	end

	// wrap is sticky; a count write loads anew, so no wrap lands then
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wrap_ff <= 1'b0;
		end else if (ce) begin
			if (!cnt_wr && nxt_count < count_ff) begin
				wrap_ff <= 1'b1;
			end else if (cnt_wr) begin
				wrap_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_hit_ff <= 5'b0_0000;
		end else if (ce) begin
			last_hit_ff <= hits;
		end
	end

	// ----------------------------------------------------------
	// fill state grant
	// ----------------------------------------------------------
	// an m fill without a forwarded rio line is demoted to e
	always_comb begin
		nxt_grant = fill.state;
		if (fill.state == ucs_pkg::UCS_ST_M && !fill.fwd_m_rio) begin
			nxt_grant = ucs_pkg::UCS_ST_E;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fill_grant_ff <= ucs_pkg::UCS_ST_I;
			fill_grant_valid_ff <= 1'b0;
		end else if (ce) begin
			fill_grant_valid_ff <= fill.valid;
			if (fill.valid) begin
				fill_grant_ff <= nxt_grant;
			end
		end
	end

	// ----------------------------------------------------------
	// modified victim writeback
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wb_req_ff <= '0;
		end else if (ce) begin
			wb_req_ff.valid <= evict.valid &&
				evict.state == ucs_pkg::UCS_ST_M;
			wb_req_ff.home_remote <= evict.home_remote;
		end
	end

	// ----------------------------------------------------------
	// outputs
	// ----------------------------------------------------------
	always_comb begin
		prdata = prdata_ff;
		pready = pready_ff;
		pslverr = pslverr_ff;
		fill_grant = fill_grant_ff;
		fill_grant_valid = fill_grant_valid_ff;
		wb_req = wb_req_ff;
	end

endmodule : ucs_top
`default_nettype wire

// [tb/ucs_monitor.sv]
// port assertions for the l3 and snoop event counter
// assumes binding into ucs_top, one pclk domain
`timescale 1ns/1ps
`default_nettype none
module ucs_monitor #(
	parameter int CNT_W = 32
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// occurrences
	input wire ucs_pkg::ucs_acc_t acc,
	input wire ucs_pkg::ucs_fill_t fill,
	input wire ucs_pkg::ucs_evict_t evict,
	input wire ucs_pkg::ucs_snoop_t snoop,
	// cache side actions
	input wire ucs_pkg::ucs_state_t fill_grant,
	input wire logic fill_grant_valid,
	input wire ucs_pkg::ucs_wb_t wb_req
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------
	// apb answer
	// ----------------------------------------------------------
	property p_rdy_setup;
		ce && psel && !penable |=> pready;
	endproperty
	a_rdy_setup: assert property (p_rdy_setup)
		else $error("no ready after setup");
	property p_rdy_one;
		ce && pready |=> !pready;
	endproperty
	a_rdy_one: assert property (p_rdy_one)
		else $error("ready stood two cycles");
	property p_err_unmapped;
		ce && psel && !penable && paddr > 12'h00c |=> pready && pslverr;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped)
		else $error("unmapped access not refused");
	property p_err_nodata;
		pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
	endproperty
	a_err_nodata: assert property (p_err_nodata)
		else $error("refused read returned data");

	// ----------------------------------------------------------
	// fills and victims
	// ----------------------------------------------------------
	property p_grant;
		ce && fill.valid |=> fill_grant_valid;
	endproperty
	a_grant: assert property (p_grant)
		else $error("fill not granted");
	property p_grant_cause;
		fill_grant_valid |-> $past(fill.valid);
	endproperty
	a_grant_cause: assert property (p_grant_cause)
		else $error("grant without fill");
	property p_m_fwd;
		fill_grant_valid && fill_grant == ucs_pkg::UCS_ST_M
			|-> $past(fill.fwd_m_rio);
	endproperty
	a_m_fwd: assert property (p_m_fwd)
		else $error("modified fill not forwarded");
	property p_m_demote;
		ce && fill.valid && fill.state == ucs_pkg::UCS_ST_M
			&& !fill.fwd_m_rio |=> fill_grant == ucs_pkg::UCS_ST_E;
	endproperty
	a_m_demote: assert property (p_m_demote)
		else $error("unforwarded modified fill kept M");
	property p_wb;
		ce && evict.valid && evict.state == ucs_pkg::UCS_ST_M
			|=> wb_req.valid && wb_req.home_remote == $past(evict.home_remote);
	endproperty
	a_wb: assert property (p_wb)
		else $error("modified victim not written back");
	property p_wb_cause;
		wb_req.valid |-> $past(evict.valid)
			&& $past(evict.state) == ucs_pkg::UCS_ST_M;
	endproperty
	a_wb_cause: assert property (p_wb_cause)
		else $error("writeback without modified victim");

	c_err: cover property (pready && pslverr);
	c_m_fill: cover property (fill_grant_valid
		&& fill_grant == ucs_pkg::UCS_ST_M);
	c_wb: cover property (wb_req.valid && wb_req.home_remote);
endmodule : ucs_monitor

bind ucs_top ucs_monitor #(.CNT_W(CNT_W)) u_mon (
	.pclk(pclk),
	.presetn(presetn),
	.ce(ce),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pstrb(pstrb),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.acc(acc),
	.fill(fill),
	.evict(evict),
	.snoop(snoop),
	.fill_grant(fill_grant),
	.fill_grant_valid(fill_grant_valid),
	.wb_req(wb_req)
);
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench: event table loop, then hand tests
// assumes ucs_top with zero-wait apb and default CNT_W
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct {
		logic [7:0] evt;
		logic [7:0] um;
		logic [3:0] aux;
		int sel;
		logic [4:0] val;
		int exp;
	} ucs_tb_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	ucs_pkg::ucs_acc_t acc = '0;
	ucs_pkg::ucs_fill_t fill = '0;
	ucs_pkg::ucs_evict_t evict = '0;
	ucs_pkg::ucs_snoop_t snoop = '0;
	ucs_pkg::ucs_state_t fill_grant;
	logic fill_grant_valid;
	ucs_pkg::ucs_wb_t wb_req;
	int failures = 0;
	int cmp_count = 0;
	ucs_tb_row_t rows[40];
	logic [31:0] rd;
	logic er;

	always #20 pclk = ~pclk;

	ucs_top dut (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.acc(acc),
		.fill(fill),
		.evict(evict),
		.snoop(snoop),
		.fill_grant(fill_grant),
		.fill_grant_valid(fill_grant_valid),
		.wb_req(wb_req)
	);

	// ----------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------
	task end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// waits on pready; only the watchdog ends a hang
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one occurrence for one cycle; returns at its sampling edge
	task occ(input int s, input logic [4:0] v);
		@(posedge pclk);
		case (s)
			0: acc <= ucs_pkg::ucs_acc_t'(v[3:0]);
			1: fill <= ucs_pkg::ucs_fill_t'(v);
			2: evict <= ucs_pkg::ucs_evict_t'(v);
			default: snoop <= ucs_pkg::ucs_snoop_t'(v);
		endcase
		@(posedge pclk);
		acc <= '0;
		fill <= '0;
		evict <= '0;
		snoop <= '0;
	endtask : occ

	task run_row(input ucs_tb_row_t r);
		apb(1'b1, ucs_pkg::ADDR_CTRL, {15'h0, 1'b1, r.um, r.evt});
		apb(1'b1, ucs_pkg::ADDR_AUX, {28'h0, r.aux});
		apb(1'b1, ucs_pkg::ADDR_COUNT, 32'h0000_0000);
		occ(r.sel, r.val);
		apb(1'b0, ucs_pkg::ADDR_COUNT, 32'h0000_0000);
		chk("count", r.exp, rd);
	endtask : run_row

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		rows = '{
			'{8'h08, 8'h01, 4'h0, 0, 5'h0c, 1},
			'{8'h08, 8'h01, 4'h0, 0, 5'h08, 0},
			'{8'h08, 8'h02, 4'h0, 0, 5'h0d, 1},
			'{8'h08, 8'h02, 4'h0, 0, 5'h0c, 0},
			'{8'h08, 8'h04, 4'h0, 0, 5'h0e, 1},
			'{8'h08, 8'h04, 4'h0, 0, 5'h0a, 0},
			'{8'h08, 8'h03, 4'h0, 0, 5'h0c, 1},
			'{8'h08, 8'h03, 4'h0, 0, 5'h0d, 1},
			'{8'h08, 8'h03, 4'h0, 0, 5'h0e, 0},
			'{8'h09, 8'h01, 4'h0, 0, 5'h08, 1},
			'{8'h09, 8'h01, 4'h0, 0, 5'h0c, 0},
			'{8'h09, 8'h02, 4'h0, 0, 5'h09, 1},
			'{8'h09, 8'h04, 4'h0, 0, 5'h0a, 1},
			'{8'h09, 8'h03, 4'h0, 0, 5'h09, 1},
			'{8'h09, 8'h03, 4'h0, 0, 5'h0a, 0},
			'{8'h0a, 8'h01, 4'h0, 1, 5'h11, 1},
			'{8'h0a, 8'h02, 4'h0, 1, 5'h12, 1},
			'{8'h0a, 8'h04, 4'h0, 1, 5'h14, 1},
			'{8'h0a, 8'h08, 4'h0, 1, 5'h18, 1},
			'{8'h0a, 8'h0f, 4'h0, 1, 5'h14, 1},
			'{8'h0a, 8'h04, 4'h0, 1, 5'h12, 0},
			'{8'h0a, 8'h01, 4'h0, 1, 5'h10, 0},
			'{8'h0a, 8'h02, 4'h0, 1, 5'h10, 1},
			'{8'h0b, 8'h01, 4'h0, 2, 5'h10, 1},
			'{8'h0b, 8'h02, 4'h0, 2, 5'h12, 1},
			'{8'h0b, 8'h04, 4'h0, 2, 5'h14, 1},
			'{8'h0b, 8'h08, 4'h0, 2, 5'h16, 1},
			'{8'h0b, 8'h10, 4'h0, 2, 5'h18, 1},
			'{8'h0b, 8'h1f, 4'h0, 2, 5'h16, 1},
			'{8'h0b, 8'h08, 4'h0, 2, 5'h10, 0},
			'{8'h0c, 8'h01, 4'h0, 3, 5'h11, 1},
			'{8'h0c, 8'h01, 4'h0, 3, 5'h18, 0},
			'{8'h0c, 8'h02, 4'h0, 3, 5'h18, 1},
			'{8'h0c, 8'h02, 4'h0, 3, 5'h11, 0},
			'{8'h0c, 8'h04, 4'h2, 3, 5'h11, 1},
			'{8'h0c, 8'h04, 4'h8, 3, 5'h14, 1},
			'{8'h0c, 8'h04, 4'h1, 3, 5'h10, 1},
			'{8'h0c, 8'h04, 4'h2, 3, 5'h10, 0},
			'{8'h0c, 8'h08, 4'h1, 3, 5'h18, 1},
			'{8'h08, 8'h01, 4'h0, 1, 5'h11, 0}
		};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			run_row(rows[i]);
		end
		$display("test event table done");
		// preload, back-to-back hits, then disabled
		apb(1'b1, ucs_pkg::ADDR_CTRL, 32'h0001_0108);
		apb(1'b1, ucs_pkg::ADDR_COUNT, 32'h0000_0005);
		@(posedge pclk);
		acc <= ucs_pkg::ucs_acc_t'(4'hc);
		repeat (3) @(posedge pclk);
		acc <= '0;
		apb(1'b0, ucs_pkg::ADDR_COUNT, 32'h0000_0000);
		chk("burst count", 32'h0000_0008, rd);
		// a frozen clock enable must drop the hit as well
		ce <= 1'b0;
		occ(0, 5'h0c);
		ce <= 1'b1;
		apb(1'b1, ucs_pkg::ADDR_CTRL, 32'h0000_0108);
		occ(0, 5'h0c);
		apb(1'b0, ucs_pkg::ADDR_COUNT, 32'h0000_0000);
		chk("disabled count", 32'h0000_0008, rd);
		// count wraps to zero, raising sticky wrap; a write clears it
		apb(1'b1, ucs_pkg::ADDR_CTRL, 32'h0001_0108);
		apb(1'b1, ucs_pkg::ADDR_COUNT, 32'hffff_ffff);
		occ(0, 5'h0c);
		apb(1'b0, ucs_pkg::ADDR_COUNT, 32'h0000_0000);
		chk("wrapped count", 32'h0000_0000, rd);
		apb(1'b0, ucs_pkg::ADDR_STATUS, 32'h0000_0000);
		chk("wrap set", 32'h0000_0100, rd);
		apb(1'b1, ucs_pkg::ADDR_COUNT, 32'h0000_0000);
		apb(1'b0, ucs_pkg::ADDR_STATUS, 32'h0000_0000);
		chk("wrap cleared", 32'h0000_0000, rd);
		$display("test burst and enable done");
		// registered outputs: look one step past the edge
		occ(1, 5'h10);
		#1;
		chk("grant valid", 32'h0000_0001, {31'h0, fill_grant_valid});
		chk("grant", {29'h0, ucs_pkg::UCS_ST_E}, {29'h0, fill_grant});
		occ(1, 5'h11);
		#1;
		chk("grant", {29'h0, ucs_pkg::UCS_ST_M}, {29'h0, fill_grant});
		occ(2, 5'h11);
		#1;
		chk("writeback", 32'h0000_0003, {30'h0, wb_req});
		occ(2, 5'h12);
		#1;
		chk("writeback", 32'h0000_0000, {30'h0, wb_req});
		$display("test grant and writeback done");
		apb(1'b1, 12'h010, 32'hffff_ffff);
		chk("write error", 32'h0000_0001, {31'h0, er});
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk("read error", 32'h0000_0001, {31'h0, er});
		chk("read data", 32'h0000_0000, rd);
		$display("test unmapped done");
		// reset in mid-run must clear everything
		apb(1'b1, ucs_pkg::ADDR_AUX, 32'h0000_000f);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("reset grant", {29'h0, ucs_pkg::UCS_ST_I}, {29'h0, fill_grant});
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ucs_pkg::ADDR_CTRL, 32'h0000_0000);
		chk("ctrl", ucs_pkg::CTRL_RST, rd);
		apb(1'b0, ucs_pkg::ADDR_AUX, 32'h0000_0000);
		chk("aux", {28'h0, ucs_pkg::AUX_RST}, rd);
		apb(1'b0, ucs_pkg::ADDR_COUNT, 32'h0000_0000);
		chk("count", 32'h0000_0000, rd);
		$display("test reset done");
		end_of_test();
	end

	// table needs under 1000 cycles; generous margin
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
